// ---- verilog/compare_skip_pkg.sv ----
package compare_skip_pkg;

  // core timing: one quarter-phase per ref_clk period
  localparam int unsigned REF_CLK_HZ      = 50_000_000;
  localparam int unsigned QUARTER_NS      = 20;
  localparam int unsigned QUARTERS        = 4;
  localparam int unsigned QUARTER_CYCLES  =
    (QUARTER_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;

  // widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned ADDR_W = 12;

  // instruction word fields
  localparam int unsigned OPC_LSB  = 9;
  localparam int unsigned ACC_BIT  = 8;
  localparam int unsigned FILE_LSB = 0;
  localparam logic [6:0]  OPC_EQUAL   = 7'h31;   // 0110 001
  localparam logic [6:0]  OPC_GREATER = 7'h32;   // 0110 010

  // access bank split and indexed offset limit
  localparam logic [7:0]        ACCESS_LOW_LIMIT  = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK   = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK  = 4'hf;

  // instruction cycles per outcome, counted in quarter-phases minus one
  localparam logic [3:0] LEN_NO_SKIP  = 4'h3;
  localparam logic [3:0] LEN_SKIP     = 4'h7;
  localparam logic [3:0] LEN_SKIP_TWO = 4'hb;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_SKIP1 = 2'b10,
    ST_SKIP2 = 2'b11
  } exec_state_t;

endpackage

// ---- verilog/quarter_phase_gen.sv ----
module quarter_phase_gen #(
  parameter int unsigned PHASES = 4
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // one-hot quarter-phase enables
  output logic [PHASES-1:0]      phase_pulse
);

  typedef struct packed {
    logic [1:0] phase;
  } gen_state_t;

  gen_state_t s_reg;
  gen_state_t s_next;

  // the phase counter is two bits wide, so only four phases can be served
  if (PHASES != 4)
  begin : g_bad_phases
    $error("quarter_phase_gen serves exactly four phases");
  end

  always_comb
  begin
    s_next       = s_reg;
    s_next.phase = s_reg.phase + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  always_comb
  begin
    phase_pulse                = '0;
    phase_pulse[s_reg.phase]   = 1'b1;
  end

endmodule // quarter_phase_gen

// ---- verilog/compare_skip_exec.sv ----
// Notes on behaviour
// - equal-compare-skip is opcode 0110 001a and greater-compare-skip is 0110 010a.
// - both compute file byte minus working register unsigned, drop it, touch no flag.
// - greater-compare-skip skips only when the file byte is strictly above the register.
// - equal-compare-skip skips only when the file byte equals the register.
// - a taken skip discards the fetched next word and runs a no-operation cycle.
// - one word; one cycle without skip, two with skip, three over a two-word instruction.
// - skipping a two-word instruction inserts two full no-operation instruction cycles.
// - access bit 0 resolves the file address in the fixed access bank.
// - access bit 1 forms the address from the bank select register and the file field.
// - extended set, access bit 0 and file address up to 95 use indexed literal offset.
module compare_skip_exec (
  // clock and reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst,
  // fetch pipeline
  input  wire logic                                 instr_valid,
  input  wire logic [compare_skip_pkg::WORD_W-1:0]  instr_word,
  input  wire logic                                 next_is_two_word,
  output logic                                      instr_taken,
  output logic                                      flush_fetch,
  output logic                                      nop_active,
  output logic                                      cycle_done,
  output logic                                      busy,
  // core state
  input  wire logic                                 ext_set_enable,
  input  wire logic [compare_skip_pkg::DATA_W-1:0]  working_register,
  input  wire logic [compare_skip_pkg::BANK_W-1:0]  bank_select_register,
  input  wire logic [compare_skip_pkg::ADDR_W-1:0]  index_base,
  // data-memory read port
  output logic                                      mem_rd_en,
  output logic [compare_skip_pkg::ADDR_W-1:0]       mem_rd_addr,
  input  wire logic [compare_skip_pkg::DATA_W-1:0]  mem_rd_data,
  // result
  output logic                                      mem_wr_en,
  output logic                                      skip_taken
);
  import compare_skip_pkg::*;

  typedef struct packed {
    exec_state_t        st;
    logic               is_gt;
    logic [ADDR_W-1:0]  addr;
    logic               skip;
    logic               two;
    logic [3:0]         len;
  } exec_regs_t;

  exec_regs_t s_reg;
  exec_regs_t s_next;

  logic [QUARTERS-1:0] q;
  logic [6:0]          opc;
  logic                acc;
  logic [7:0]          fld;
  logic                is_eq_op;
  logic                is_gt_op;
  logic [ADDR_W-1:0]   dec_addr;
  logic [DATA_W:0]     diff;
  logic                eq_hit;
  logic                gt_hit;

  quarter_phase_gen #(
    .PHASES (QUARTERS)
  ) u_phase (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .phase_pulse (q)
  );

  assign opc      = instr_word[OPC_LSB +: 7];
  assign acc      = instr_word[ACC_BIT];
  assign fld      = instr_word[FILE_LSB +: 8];
  assign is_eq_op = (opc == OPC_EQUAL);
  assign is_gt_op = (opc == OPC_GREATER);

  always_comb
  begin
    if (acc)
      dec_addr = {bank_select_register, fld};
    else if (ext_set_enable && (fld <= ACCESS_LOW_LIMIT))
      dec_addr = ADDR_W'(index_base + {4'h0, fld});
    else if (fld <= ACCESS_LOW_LIMIT)
      dec_addr = {ACCESS_LOW_BANK, fld};
    else
      dec_addr = {ACCESS_HIGH_BANK, fld};
  end

  // borrow-extended difference; only its zero and borrow are used, flags stay put
  assign diff   = {1'b0, mem_rd_data} - {1'b0, working_register};
  assign eq_hit = (diff == '0);
  assign gt_hit = !diff[DATA_W] && !eq_hit;

  assign instr_taken = (s_reg.st == ST_IDLE) && q[0] && instr_valid && (is_eq_op || is_gt_op);
  assign mem_rd_en   = (s_reg.st == ST_EXEC) && q[1];
  assign mem_rd_addr = s_reg.addr;
  assign mem_wr_en   = 1'b0;
  assign flush_fetch = (s_reg.st == ST_EXEC) && q[3] && s_reg.skip;
  assign skip_taken  = flush_fetch;
  assign nop_active  = (s_reg.st == ST_SKIP1) || (s_reg.st == ST_SKIP2);
  assign busy        = (s_reg.st != ST_IDLE);
  assign cycle_done  = q[3] && (((s_reg.st == ST_EXEC) && !s_reg.skip)
                       || ((s_reg.st == ST_SKIP1) && !s_reg.two)
                       || (s_reg.st == ST_SKIP2));

  always_comb
  begin
    s_next = s_reg;
    if (s_reg.st != ST_IDLE)
      s_next.len = s_reg.len + 4'h1;
    case (s_reg.st)
      ST_IDLE:
      begin
        if (instr_taken)
        begin
          s_next.st    = ST_EXEC;
          s_next.is_gt = is_gt_op;
          s_next.addr  = dec_addr;
          s_next.skip  = 1'b0;
          s_next.two   = 1'b0;
          s_next.len   = 4'h1;
        end
      end
      ST_EXEC:
      begin
        if (q[2])
        begin
          s_next.skip = s_reg.is_gt ? gt_hit : eq_hit;
          s_next.two  = next_is_two_word;
        end
        if (q[3])
          s_next.st = s_reg.skip ? ST_SKIP1 : ST_IDLE;
      end
      ST_SKIP1:
      begin
        if (q[3])
          s_next.st = s_reg.two ? ST_SKIP2 : ST_IDLE;
      end
      ST_SKIP2:
      begin
        if (q[3])
          s_next.st = ST_IDLE;
      end
      default:
      begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_reg <= '{st: ST_IDLE, is_gt: 1'b0, addr: '0, skip: 1'b0, two: 1'b0, len: 4'h0};
    else
      s_reg <= s_next;
  end

  sequence s_decoded;
    instr_taken;
  endsequence

  sequence s_read_then_process;
    ##1 mem_rd_en ##1 !mem_rd_en;
  endsequence

  property p_decode_eq;
    @(posedge ref_clk) disable iff (rst)
      instr_taken |-> (opc == OPC_EQUAL) || (opc == OPC_GREATER);
  endproperty
  a_decode_eq: assert property (p_decode_eq) else $error("decoded a foreign opcode");

  property p_no_write;
    @(posedge ref_clk) disable iff (rst)
      busy |-> !mem_wr_en;
  endproperty
  a_no_write: assert property (p_no_write) else $error("compare wrote memory");

  property p_gt_skip;
    @(posedge ref_clk) disable iff (rst)
      (s_reg.st == ST_EXEC) && q[2] && s_reg.is_gt
      |=> s_reg.skip == $past(mem_rd_data > working_register);
  endproperty
  a_gt_skip: assert property (p_gt_skip) else $error("greater skip decision wrong");

  property p_eq_skip;
    @(posedge ref_clk) disable iff (rst)
      (s_reg.st == ST_EXEC) && q[2] && !s_reg.is_gt
      |=> s_reg.skip == $past(mem_rd_data == working_register);
  endproperty
  a_eq_skip: assert property (p_eq_skip) else $error("equal skip decision wrong");

  property p_flush_nop;
    @(posedge ref_clk) disable iff (rst)
      flush_fetch |=> nop_active [*4];
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("skip without nop cycle");

  property p_length;
    @(posedge ref_clk) disable iff (rst)
      cycle_done |-> s_reg.len == (!s_reg.skip ? LEN_NO_SKIP
                                   : (s_reg.two ? LEN_SKIP_TWO : LEN_SKIP));
  endproperty
  a_length: assert property (p_length) else $error("instruction length wrong");

  property p_two_word;
    @(posedge ref_clk) disable iff (rst)
      flush_fetch && s_reg.two |=> nop_active [*8];
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word skip too short");

  property p_access_bank;
    @(posedge ref_clk) disable iff (rst)
      instr_taken && !acc && !(ext_set_enable && fld <= ACCESS_LOW_LIMIT)
      |=> s_reg.addr[ADDR_W-1 -: BANK_W]
          == $past((fld <= ACCESS_LOW_LIMIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK)
          && s_reg.addr[7:0] == $past(fld);
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

  property p_banked;
    @(posedge ref_clk) disable iff (rst)
      instr_taken && acc |=> s_reg.addr == $past({bank_select_register, fld});
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge ref_clk) disable iff (rst)
      instr_taken && !acc && ext_set_enable && (fld <= ACCESS_LOW_LIMIT)
      |=> s_reg.addr == $past(ADDR_W'(index_base + {4'h0, fld}));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_phases;
    @(posedge ref_clk) disable iff (rst)
      s_decoded |-> s_read_then_process ##1 (q[3] && !mem_rd_en && !mem_wr_en);
  endproperty
  a_phases: assert property (p_phases) else $error("quarter-phase order wrong");

endmodule // compare_skip_exec

// ---- tb/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import compare_skip_pkg::*;

  logic                ref_clk;
  logic                rst;
  logic                instr_valid;
  logic [WORD_W-1:0]   instr_word;
  logic                next_is_two_word;
  logic                instr_taken;
  logic                flush_fetch;
  logic                nop_active;
  logic                cycle_done;
  logic                busy;
  logic                ext_set_enable;
  logic [DATA_W-1:0]   working_register;
  logic [BANK_W-1:0]   bank_select_register;
  logic [ADDR_W-1:0]   index_base;
  logic                mem_rd_en;
  logic [ADDR_W-1:0]   mem_rd_addr;
  logic [DATA_W-1:0]   mem_rd_data;
  logic                mem_wr_en;
  logic                skip_taken;
  int                  failures;
  int                  checked;

  compare_skip_exec dut (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .next_is_two_word     (next_is_two_word),
    .instr_taken          (instr_taken),
    .flush_fetch          (flush_fetch),
    .nop_active           (nop_active),
    .cycle_done           (cycle_done),
    .busy                 (busy),
    .ext_set_enable       (ext_set_enable),
    .working_register     (working_register),
    .bank_select_register (bank_select_register),
    .index_base           (index_base),
    .mem_rd_en            (mem_rd_en),
    .mem_rd_addr          (mem_rd_addr),
    .mem_rd_data          (mem_rd_data),
    .mem_wr_en            (mem_wr_en),
    .skip_taken           (skip_taken)
  );

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one compare from offer to completion; phase found by the accept pulse
  task automatic run_cmp(input logic gt, input logic acc, input logic [7:0] f,
                         input logic [7:0] data, input logic two, input logic skip,
                         input logic [11:0] addr);
    int n;
    instr_word = {(gt ? OPC_GREATER : OPC_EQUAL), acc, f};
    next_is_two_word = two;
    instr_valid = 1'b1;
    #1;
    n = 0;
    while (instr_taken !== 1'b1 && n < 4)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (instr_taken !== 1'b1)
    begin
      failures++;
      stop_test();
    end
    @(posedge ref_clk);
    #1;
    mem_rd_data = data;
    check(mem_rd_en, 1'b1);
    check(nop_active, 1'b0);
    check(mem_rd_addr, addr);
    check(busy, 1'b1);
    @(posedge ref_clk);
    #1;
    check(mem_wr_en, 1'b0);
    @(posedge ref_clk);
    #1;
    check(flush_fetch, skip);
    check(skip_taken, skip);
    check(cycle_done, !skip);
    check(mem_wr_en, 1'b0);
    n = 0;
    while (cycle_done !== 1'b1 && n < 12)
    begin
      @(posedge ref_clk);
      #1;
      check(nop_active, 1'b1);
      check(instr_taken, 1'b0);
      n++;
    end
    if (cycle_done !== 1'b1)
    begin
      failures++;
      stop_test();
    end
    check(16'(n), skip ? (two ? 16'h8 : 16'h4) : 16'h0);
    // valid stayed high through the compare, so a busy core must have ignored it
    instr_valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // words that are not one of the two compares must never be accepted
  task automatic refuse(input logic [15:0] w);
    instr_word = w;
    instr_valid = 1'b1;
    #1;
    repeat (8)
    begin
      check(instr_taken, 1'b0);
      check(busy, 1'b0);
      @(posedge ref_clk);
      #1;
    end
    instr_valid = 1'b0;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    stop_test();
  end

  initial
  begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    next_is_two_word = 1'b0;
    ext_set_enable = 1'b0;
    working_register = 8'h55;
    bank_select_register = 4'h3;
    index_base = 12'h123;
    mem_rd_data = 8'h00;
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    run_cmp(1'b0, 1'b1, 8'h42, 8'h55, 1'b0, 1'b1, 12'h342);
    run_cmp(1'b0, 1'b1, 8'h42, 8'h54, 1'b1, 1'b0, 12'h342);
    working_register = 8'h7f;
    run_cmp(1'b1, 1'b1, 8'h10, 8'h80, 1'b1, 1'b1, 12'h310);
    run_cmp(1'b1, 1'b1, 8'h10, 8'h7f, 1'b0, 1'b0, 12'h310);
    working_register = 8'h80;
    run_cmp(1'b1, 1'b0, 8'h5f, 8'h7f, 1'b0, 1'b0, 12'h05f);
    run_cmp(1'b1, 1'b0, 8'h60, 8'hff, 1'b0, 1'b1, 12'hf60);
    ext_set_enable = 1'b1;
    run_cmp(1'b0, 1'b0, 8'h10, 8'h80, 1'b0, 1'b1, 12'h133);
    run_cmp(1'b0, 1'b0, 8'h60, 8'h80, 1'b1, 1'b1, 12'hf60);
    run_cmp(1'b1, 1'b1, 8'h5f, 8'h00, 1'b0, 1'b0, 12'h35f);
    refuse(16'h6055);
    refuse(16'h6e00);
    stop_test();
  end
endmodule // tb
